// [logic/uepf_pkg.sv]
package uepf_pkg;
    // *****************************************************************
    // sizes and address map
    // *****************************************************************
    localparam int          NUM_EP       = 3;      // endpoints per direction
    localparam int          NUM_FIFO     = 6;      // tx fifos 0..2, rx fifos 3..5
    localparam int          MEM_DEPTH    = 64;     // storage slots per fifo
    localparam logic [6:0]  CAP_SMALL    = 7'h20;  // first two fifos of each direction
    localparam logic [6:0]  CAP_LARGE    = 7'h40;  // third fifo of each direction
    localparam int          ADDR_W       = 8;
    localparam logic [1:0]  GRP_TX       = 2'h0;   // paddr[7:6]
    localparam logic [1:0]  GRP_RX       = 2'h1;
    localparam logic [1:0]  GRP_MISC     = 2'h2;
    localparam logic [1:0]  SUB_DATA     = 2'h0;   // paddr[3:2]
    localparam logic [1:0]  SUB_CMD      = 2'h1;
    localparam logic [1:0]  SUB_STAT     = 2'h2;
    localparam logic [7:0]  FIFO_WARNING_EVENT_REG_ADDR    = 8'h80;  // fifo_warning_event_reg
    localparam int          LAST_BIT     = 7;      // tx_command_reg last-packet bit
    localparam int          FLAG_BIT     = 7;      // status reg underrun/overrun bit
    // *****************************************************************
    // reset values
    // *****************************************************************
    localparam logic [5:0]  PTR_RST      = 6'h00;
    localparam logic [6:0]  CNT_RST      = 7'h00;
    localparam logic [6:0]  THR_RST      = 7'h00;
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;   // rx input buffer entries

    // byte arriving from the endpoint controller
    typedef struct packed {
        logic       valid;
        logic [1:0] ep;
        logic [7:0] data;
    } uepf_rx_word_type;

    // byte request from the endpoint controller
    typedef struct packed {
        logic       take;
        logic [1:0] ep;
    } uepf_tx_req_type;

    typedef struct packed {
        logic [1:0] ep;
        logic [7:0] data;
    } uepf_buf_entry_type;

    typedef struct packed {
        logic [NUM_FIFO-1:0][MEM_DEPTH-1:0][7:0] mem;
        logic [NUM_FIFO-1:0][5:0]                rd_ptr;
        logic [NUM_FIFO-1:0][5:0]                wr_ptr;
        logic [NUM_FIFO-1:0][6:0]                cnt;
        logic [NUM_EP-1:0][7:0]                  rx_last_byte;
        logic [NUM_EP-1:0][6:0]                  tx_thr;
        logic [NUM_EP-1:0][6:0]                  rx_thr;
        logic [NUM_EP-1:0]                       tx_last;
        logic [NUM_EP-1:0]                       tx_unrun;
        logic [NUM_EP-1:0]                       rx_ovrun;
        logic [NUM_FIFO-1:0]                     warn;
        logic [1:0][9:0]                         buf_q;
        logic [1:0]                              buf_cnt;
        logic                                    buf_ready;
        logic                                    pready;
        logic                                    pslverr;
        logic [31:0]                             prdata;
        logic [7:0]                              tx_data;
        logic                                    tx_valid;
    } uepf_state_type;
endpackage : uepf_pkg

// [logic/uepf_fifos.sv]
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module uepf_fifos
    import uepf_pkg::*;
#(
    parameter logic [6:0] CAP_S = CAP_SMALL,   // capacity of fifos one and two
    parameter logic [6:0] CAP_L = CAP_LARGE    // capacity of fifo three
) (
    input  wire logic              core_clk,      // device clock
    input  wire logic              arst_n,        // async reset, active low
    input  wire logic              psel,          // apb select
    input  wire logic              penable,       // apb enable
    input  wire logic              pwrite,        // apb direction
    input  wire logic [ADDR_W-1:0] paddr,         // apb byte address
    input  wire logic [31:0]       pwdata,        // apb write data
    output logic      [31:0]       prdata,        // apb read data
    output logic                   pready,        // apb ready
    output logic                   pslverr,       // apb error on unmapped address
    input  wire uepf_tx_req_type   tx_req,        // controller takes a tx byte
    output logic      [7:0]        tx_data,       // byte taken
    output logic                   tx_data_valid, // tx_data holds a fresh byte
    input  wire uepf_rx_word_type  rx_in,         // byte from controller
    output logic                   rx_in_ready,   // buffer accepts rx_in
    output logic      [5:0]        warn_flags     // rx warnings [5:3], tx warnings [2:0]
);
    // *****************************************************************
    // helpers
    // *****************************************************************
    function automatic logic [6:0] cap_of(input int k);
        cap_of = (k == 2 || k == 5) ? CAP_L : CAP_S;
    endfunction : cap_of

    function automatic logic [5:0] ptr_inc(input logic [5:0] p, input int k);
        logic [6:0] n;
        n = {1'b0, p} + 7'h01;
        ptr_inc = (n == cap_of(k)) ? PTR_RST : n[5:0];
    endfunction : ptr_inc

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [1:0] g;
        g = a[7:6];
        addr_ok = (a == FIFO_WARNING_EVENT_REG_ADDR) ||
                  ((g == GRP_TX || g == GRP_RX) && a[5:4] != 2'h3 &&
                   a[3:2] != 2'h3 && a[1:0] == 2'h0);
    endfunction : addr_ok

    uepf_state_type s_r;
    uepf_state_type s_nxt;

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb begin
        logic [NUM_FIFO-1:0] inc;
        logic [NUM_FIFO-1:0] dec;
        logic                access;
        logic                done;
        logic [1:0]          grp;
        logic [1:0]          sub;
        int                  e;
        int                  k;
        uepf_buf_entry_type  head;
        logic                stall;
        logic                pop;
        logic                push;
        logic [31:0]         rd;
        inc    = '0;
        dec    = '0;
        access = psel && penable;
        done   = access && s_r.pready;
        grp    = paddr[7:6];
        sub    = paddr[3:2];
        e      = int'(paddr[5:4]);
        k      = 0;
        head   = s_r.buf_q[0];
        pop    = 1'b0;
        push   = 1'b0;
        rd     = 32'h0000_0000;
        stall  = 1'b0;
        s_nxt  = s_r;
        s_nxt.tx_valid = 1'b0;
        s_nxt.pready   = access && !s_r.pready;

        // apb: answer prepared in the first access cycle
        if (access && !s_r.pready) begin
            if (paddr == FIFO_WARNING_EVENT_REG_ADDR) begin
                rd[5:0] = s_r.warn;
            end else if (grp == GRP_TX && sub == SUB_CMD) begin
                rd[7:0] = {s_r.tx_last[e], s_r.tx_thr[e]};
            end else if (grp == GRP_TX && sub == SUB_STAT) begin
                rd[7:0] = {s_r.tx_unrun[e], cap_of(e) - s_r.cnt[e]};
            end else if (grp == GRP_RX && sub == SUB_DATA) begin
                // empty fifo repeats the last byte read
                rd[7:0] = (s_r.cnt[e+3] != CNT_RST) ? s_r.mem[e+3][s_r.rd_ptr[e+3]]
                                                    : s_r.rx_last_byte[e];
            end else if (grp == GRP_RX && sub == SUB_CMD) begin
                rd[6:0] = s_r.rx_thr[e];
            end else if (grp == GRP_RX && sub == SUB_STAT) begin
                rd[7:0] = {s_r.rx_ovrun[e], s_r.cnt[e+3]};
            end
            s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd;
            s_nxt.pslverr = !addr_ok(paddr);
        end

        // apb: effects land at the edge that completes the transfer
        if (done && addr_ok(paddr) && paddr != FIFO_WARNING_EVENT_REG_ADDR) begin
            if (pwrite && grp == GRP_TX && sub == SUB_DATA) begin
                // a full fifo ignores the write
                if (s_r.cnt[e] != cap_of(e)) begin
                    s_nxt.mem[e][s_r.wr_ptr[e]] = pwdata[7:0];
                    s_nxt.wr_ptr[e] = ptr_inc(s_r.wr_ptr[e], e);
                    inc[e] = 1'b1;
                end
            end else if (pwrite && grp == GRP_TX && sub == SUB_CMD) begin
                s_nxt.tx_thr[e]  = pwdata[6:0];
                s_nxt.tx_last[e] = pwdata[LAST_BIT];
            end else if (pwrite && grp == GRP_RX && sub == SUB_CMD) begin
                s_nxt.rx_thr[e] = pwdata[6:0];
            end else if (!pwrite && grp == GRP_TX && sub == SUB_STAT) begin
                s_nxt.tx_unrun[e] = 1'b0; // cleared on read, a new event wins below
            end else if (!pwrite && grp == GRP_RX && sub == SUB_STAT) begin
                s_nxt.rx_ovrun[e] = 1'b0;
            end else if (!pwrite && grp == GRP_RX && sub == SUB_DATA) begin
                if (s_r.cnt[e+3] != CNT_RST) begin
                    s_nxt.rx_last_byte[e] = s_r.mem[e+3][s_r.rd_ptr[e+3]];
                    s_nxt.rd_ptr[e+3] = ptr_inc(s_r.rd_ptr[e+3], e + 3);
                    dec[e+3] = 1'b1;
                end
            end
        end

        // controller takes a tx byte
        if (tx_req.take && tx_req.ep != 2'h3) begin
            k = int'(tx_req.ep);
            if (s_r.cnt[k] == CNT_RST) begin
                // pointer held at the write pointer
                if (!s_r.tx_last[k]) begin
                    s_nxt.tx_unrun[k] = 1'b1;
                end
            end else begin
                s_nxt.tx_data  = s_r.mem[k][s_r.rd_ptr[k]];
                s_nxt.tx_valid = 1'b1;
                s_nxt.rd_ptr[k] = ptr_inc(s_r.rd_ptr[k], k);
                dec[k] = 1'b1;
            end
        end

        // rx buffer drain, stalled while firmware touches an rx register
        stall = psel && grp == GRP_RX;
        if (s_r.buf_cnt != 2'h0 && !stall && head.ep != 2'h3) begin
            k   = int'(head.ep) + 3;
            pop = 1'b1;
            if (s_r.cnt[k] == cap_of(k)) begin
                s_nxt.rx_ovrun[k-3] = 1'b1;
            end else begin
                s_nxt.mem[k][s_r.wr_ptr[k]] = head.data;
                s_nxt.wr_ptr[k] = ptr_inc(s_r.wr_ptr[k], k);
                inc[k] = 1'b1;
            end
        end else if (s_r.buf_cnt != 2'h0 && !stall) begin
            pop = 1'b1; // no such fifo, drop the byte
        end

        // two-entry rx buffer
        push = rx_in.valid && s_r.buf_ready;
        if (pop) begin
            s_nxt.buf_q[0] = s_r.buf_q[1];
        end
        if (push) begin
            s_nxt.buf_q[s_r.buf_cnt - {1'b0, pop}] = {rx_in.ep, rx_in.data};
        end
        s_nxt.buf_cnt   = s_r.buf_cnt + {1'b0, push} - {1'b0, pop};
        s_nxt.buf_ready = s_nxt.buf_cnt != BUF_DEPTH;

        // levels and warnings
        for (int i = 0; i < NUM_FIFO; i++) begin
            s_nxt.cnt[i] = s_r.cnt[i] + {6'h00, inc[i]} - {6'h00, dec[i]};
        end
        for (int i = 0; i < NUM_EP; i++) begin
            s_nxt.warn[i]   = s_r.cnt[i] <= s_r.tx_thr[i];
            s_nxt.warn[i+3] = (cap_of(i + 3) - s_r.cnt[i+3]) <= s_r.rx_thr[i];
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign prdata        = s_r.prdata;
    assign pready        = s_r.pready;
    assign pslverr       = s_r.pslverr;
    assign tx_data       = s_r.tx_data;
    assign tx_data_valid = s_r.tx_valid;
    assign rx_in_ready   = s_r.buf_ready;
    assign warn_flags    = s_r.warn;

    // *****************************************************************
    // checks
    // *****************************************************************
    logic [5:0] tx0_rd;
    logic [5:0] tx0_wr;
    logic [6:0] tx0_cnt;
    logic [5:0] rx0_rd;
    logic       tx0_low;
    logic       tx0_take;
    logic       rx0_drain;
    assign tx0_rd    = s_r.rd_ptr[0];
    assign tx0_wr    = s_r.wr_ptr[0];
    assign tx0_cnt   = s_r.cnt[0];
    assign rx0_rd    = s_r.rd_ptr[3];
    assign tx0_low   = s_r.cnt[0] <= s_r.tx_thr[0];
    assign tx0_take  = tx_req.take && tx_req.ep == 2'h0;
    assign rx0_drain = s_r.buf_cnt != 2'h0 && s_r.buf_q[0][9:8] == 2'h0 &&
                       !(psel && paddr[7:6] == GRP_RX);

    // receive side and firmware strobe helpers for the first fifo of each direction
    logic [5:0] rx0_wr;
    logic [6:0] rx0_cnt;
    logic [6:0] rx0_space;
    logic [6:0] rx0_thr;
    logic [7:0] rx0_last;
    logic [7:0] tx0_head;
    logic       tx0_fw_write;
    logic       rx0_fw_read;
    assign rx0_wr       = s_r.wr_ptr[3];
    assign rx0_cnt      = s_r.cnt[3];
    assign rx0_space    = 7'h20 - s_r.cnt[3];
    assign rx0_thr      = s_r.rx_thr[0];
    assign rx0_last     = s_r.rx_last_byte[0];
    assign tx0_head     = s_r.mem[0][s_r.rd_ptr[0]];
    assign tx0_fw_write = psel && penable && s_r.pready && pwrite && paddr == 8'h00;
    assign rx0_fw_read  = psel && penable && s_r.pready && !pwrite && paddr == 8'h40;

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_stat0_s;
        psel && penable && !pwrite && !s_r.pready && paddr == 8'h08;
    endsequence
    sequence apb_rx0_empty_s;
        psel && penable && !pwrite && !s_r.pready && paddr == 8'h40 && rx0_cnt == 7'h00;
    endsequence
    sequence apb_rxstat0_s;
        psel && penable && !pwrite && !s_r.pready && paddr == 8'h48;
    endsequence

    tx_read_step_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_take && tx0_cnt != 7'h00 |=>
        tx0_rd == (($past(tx0_rd) == 6'h1F) ? 6'h00 : $past(tx0_rd) + 6'h01))
        else $error("tx read pointer did not step");
    tx_read_hold_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_take && tx0_cnt == 7'h00 |=> tx0_rd == $past(tx0_rd))
        else $error("tx read pointer passed write pointer");
    tx_underrun_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_take && tx0_cnt == 7'h00 && !s_r.tx_last[0] |=> s_r.tx_unrun[0])
        else $error("tx underrun not flagged");
    tx_full_drop_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        psel && penable && s_r.pready && pwrite && paddr == 8'h00 &&
        tx0_cnt == 7'h20 |=> tx0_wr == $past(tx0_wr))
        else $error("write into full tx fifo accepted");
    tx_free_read_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        apb_setup_s ##1 apb_stat0_s |=> prdata[6:0] == 7'h20 - $past(tx0_cnt))
        else $error("tx free count wrong");
    tx_warn_flag_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> warn_flags[0] == $past(tx0_low))
        else $error("tx low warning wrong");
    rx_empty_hold_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        psel && penable && s_r.pready && !pwrite && paddr == 8'h40 &&
        s_r.cnt[3] == 7'h00 |=> rx0_rd == $past(rx0_rd))
        else $error("rx read pointer moved on empty fifo");
    rx_overrun_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        rx0_drain && s_r.cnt[3] == 7'h20 |=> s_r.rx_ovrun[0] ##1 1'b1)
        else $error("rx overrun not flagged");

    // pointer steps on the write side and on the firmware read side
    tx_write_step_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_fw_write && tx0_cnt != 7'h20 |=>
        tx0_wr == (($past(tx0_wr) == 6'h1F) ? 6'h00 : $past(tx0_wr) + 6'h01))
        else $error("tx write pointer did not step");
    rx_read_step_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        rx0_fw_read && rx0_cnt != 7'h00 |=>
        rx0_rd == (($past(rx0_rd) == 6'h1F) ? 6'h00 : $past(rx0_rd) + 6'h01))
        else $error("rx read pointer did not step");
    rx_write_step_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        rx0_drain && rx0_cnt != 7'h20 |=>
        rx0_wr == (($past(rx0_wr) == 6'h1F) ? 6'h00 : $past(rx0_wr) + 6'h01))
        else $error("rx write pointer did not step");
    rx_full_hold_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        rx0_drain && rx0_cnt == 7'h20 |=> rx0_wr == $past(rx0_wr))
        else $error("rx write pointer moved on full fifo");

    // levels, bounds and the data that reads hand back
    tx_level_ptrs_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_cnt <= 7'h20 && (tx0_cnt == 7'h20 || tx0_cnt[4:0] == 5'(tx0_wr - tx0_rd)))
        else $error("tx pending level disagrees with pointers");
    cap_bound_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_rd < 6'h20 && tx0_wr < 6'h20 && rx0_rd < 6'h20 && rx0_wr < 6'h20)
        else $error("pointer beyond fifo capacity");
    tx_data_out_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        tx0_take && tx0_cnt != 7'h00 |=> tx_data_valid && tx_data == $past(tx0_head))
        else $error("tx byte not handed out");
    rx_empty_data_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        apb_setup_s ##1 apb_rx0_empty_s |=> prdata[7:0] == $past(rx0_last))
        else $error("empty rx read did not repeat last byte");
    rx_avail_read_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        apb_setup_s ##1 apb_rxstat0_s |=> prdata[6:0] == $past(rx0_cnt))
        else $error("rx available count wrong");
    rx_warn_flag_a : assert property (@(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> warn_flags[3] == ($past(rx0_space) <= $past(rx0_thr)))
        else $error("rx space warning wrong");
    reset_clear_a : assert property (@(posedge core_clk)
        !arst_n ##1 !arst_n |-> tx0_cnt == 7'h00 && tx0_rd == 6'h00 && tx0_wr == 6'h00 &&
        rx0_cnt == 7'h00 && rx0_rd == 6'h00 && rx0_wr == 6'h00)
        else $error("pointers not cleared by reset");
endmodule : uepf_fifos
`default_nettype wire

// [verif/uepf_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module uepf_ctl_model
    import uepf_pkg::*;
(
    input  wire logic         core_clk,      // device clock
    output var uepf_tx_req_type  tx_req,     // byte requests
    input  wire logic [7:0]   tx_data,       // byte taken
    input  wire logic         tx_data_valid, // byte is fresh
    output var uepf_rx_word_type rx_in,      // received bytes
    input  wire logic         rx_in_ready    // buffer accepts
);
    // **********
    // endpoint controller side
    // **********
    initial begin
        tx_req = '0;
        rx_in  = '0;
    end
    // one byte per request, answer sampled one cycle after the request is taken
    task automatic take_byte(input logic [1:0] ep, output logic [7:0] b, output logic got);
        @(posedge core_clk);
        tx_req <= '{take: 1'b1, ep: ep};
        @(posedge core_clk);
        tx_req.take <= 1'b0;
        @(posedge core_clk);
        got = tx_data_valid;
        b   = tx_data;
    endtask : take_byte
    // held until ready; released lines show the inverse value
    task automatic send_byte(input logic [1:0] ep, input logic [7:0] b);
        @(posedge core_clk);
        rx_in <= '{valid: 1'b1, ep: ep, data: b};
        do begin
            @(posedge core_clk);
        end while (rx_in_ready !== 1'b1);
        rx_in <= '{valid: 1'b0, ep: ~ep, data: ~b};
    endtask : send_byte
endmodule : uepf_ctl_model
`default_nettype wire

// [verif/usb_endpoint_data_fifos_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_data_fifos_tb;
    import uepf_pkg::*;
    logic             core_clk;
    logic             arst_n;
    logic             psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata;
    uepf_tx_req_type  tx_req;
    uepf_rx_word_type rx_in;
    logic [7:0]       tx_data, b;
    logic             tx_data_valid, rx_in_ready, g;
    logic [5:0]       warn_flags;
    logic [31:0]      r;
    int               bad_count, n_checks, cycles;

    uepf_fifos dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_req(tx_req), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .rx_in(rx_in), .rx_in_ready(rx_in_ready), .warn_flags(warn_flags));
    uepf_ctl_model ctl (.core_clk(core_clk), .tx_req(tx_req), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .rx_in(rx_in), .rx_in_ready(rx_in_ready));

    // **********
    // clock and hang guard
    // **********
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            bad_count++;
            print_verdict();
        end
    end
    // **********
    // bus cycles and compares
    // **********
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_flag(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag
    // **********
    // scenarios
    // **********
    task automatic test_reset();
        @(posedge core_clk);
        check_val("tx warn at reset", 32'h7, {29'h0, warn_flags[2:0]});
        check_flag("rx ready idle", 1'b1, rx_in_ready);
        apb(1'b0, 8'h08, 32'h0); check_val("tx0 status", 32'h20, r);
        check_flag("mapped err", 1'b0, last_err);
        apb(1'b0, 8'h28, 32'h0); check_val("tx2 status", 32'h40, r);
        apb(1'b0, 8'h48, 32'h0); check_val("rx0 status", 32'h00, r);
        apb(1'b0, 8'hC0, 32'h0); check_flag("unmapped err", 1'b1, last_err);
        apb(1'b1, 8'h64, 32'h3F); repeat (3) @(posedge core_clk);
        check_flag("rx2 warn thr 63", 1'b0, warn_flags[5]);
        apb(1'b1, 8'h64, 32'h40); repeat (3) @(posedge core_clk);
        check_flag("rx2 warn thr 64", 1'b1, warn_flags[5]);
        apb(1'b1, 8'h64, 32'h00);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_tx_stream();
        for (int i = 0; i < 32; i++) apb(1'b1, 8'h00, 32'(i));
        apb(1'b1, 8'h00, 32'hFF);
        apb(1'b0, 8'h08, 32'h0); check_val("tx0 free when full", 32'h0, r);
        for (int i = 0; i < 64; i++) begin
            ctl.take_byte(2'h0, b, g);
            check_val("tx0 byte", {23'h0, 1'b1, 8'(i)}, {23'h0, g, b});
            if (i < 32) apb(1'b1, 8'h00, 32'(i + 32));
        end
        ctl.take_byte(2'h0, b, g); check_flag("tx0 empty take", 1'b0, g);
        apb(1'b0, 8'h08, 32'h0); check_val("tx0 underrun", 32'hA0, r);
        apb(1'b0, 8'h08, 32'h0); check_val("tx0 flag cleared", 32'h20, r);
        apb(1'b1, 8'h04, 32'h80);
        ctl.take_byte(2'h0, b, g);
        apb(1'b0, 8'h08, 32'h0); check_val("tx0 last no underrun", 32'h20, r);
        apb(1'b1, 8'h04, 32'h00);
        apb(1'b1, 8'h00, 32'h5A);
        ctl.take_byte(2'h0, b, g); check_val("tx0 after empty", 32'h15A, {23'h0, g, b});
        $display("test_tx_stream done");
    endtask : test_tx_stream
    task automatic test_tx_warn();
        apb(1'b1, 8'h14, 32'h02);
        for (int i = 0; i < 4; i++) apb(1'b1, 8'h10, 32'h30 + 32'(i));
        repeat (3) @(posedge core_clk);
        check_flag("tx1 warn level 4", 1'b0, warn_flags[1]);
        apb(1'b0, 8'h18, 32'h0); check_val("tx1 free", 32'h1C, r);
        ctl.take_byte(2'h1, b, g);
        ctl.take_byte(2'h1, b, g);
        repeat (3) @(posedge core_clk);
        check_flag("tx1 warn level 2", 1'b1, warn_flags[1]);
        apb(1'b0, 8'h18, 32'h0); check_val("tx1 free after takes", 32'h1E, r);
        $display("test_tx_warn done");
    endtask : test_tx_warn
    task automatic test_rx();
        for (int i = 0; i < 3; i++) ctl.send_byte(2'h0, 8'hC0 + 8'(i));
        repeat (4) @(posedge core_clk);
        apb(1'b0, 8'h48, 32'h0); check_val("rx0 avail", 32'h3, r);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'h40, 32'h0); check_val("rx0 byte", 32'hC0 + 32'(i), r);
        end
        apb(1'b0, 8'h40, 32'h0); check_val("rx0 empty read", 32'hC2, r);
        apb(1'b0, 8'h48, 32'h0); check_val("rx0 avail empty", 32'h0, r);
        for (int i = 0; i < 33; i++) ctl.send_byte(2'h0, 8'(i));
        repeat (4) @(posedge core_clk);
        check_flag("rx0 warn full", 1'b1, warn_flags[3]);
        apb(1'b0, 8'h48, 32'h0); check_val("rx0 overrun", 32'hA0, r);
        for (int i = 0; i < 32; i++) begin
            apb(1'b0, 8'h40, 32'h0); check_val("rx0 wrapped byte", 32'(i), r);
        end
        repeat (3) @(posedge core_clk);
        check_flag("rx0 warn drained", 1'b0, warn_flags[3]);
        ctl.send_byte(2'h3, 8'h77);
        repeat (3) @(posedge core_clk);
        apb(1'b0, 8'h48, 32'h0);
        check_val("rx ep3 dropped", 32'h0, r);
        ctl.take_byte(2'h3, b, g);
        check_flag("tx ep3 no byte", 1'b0, g);
        $display("test_rx done");
    endtask : test_rx
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // **********
    // main sequence
    // **********
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        test_reset();
        test_tx_stream();
        test_tx_warn();
        test_rx();
        print_verdict();
    end
endmodule : usb_endpoint_data_fifos_tb
`default_nettype wire
